// *** pkg/rcc_pkg.sv ***
package rcc_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets, one 32-bit word each)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_EVENT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MASK  = 4'hc;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_POLY  = 0;
  localparam int CTRL_RXEN  = 1;
  localparam int STAT_RESOK = 16;
  localparam int STAT_ACT   = 17;
  localparam int EV_PASS    = 0;
  localparam int EV_FAIL    = 1;
  localparam int EV_W       = 2;

  // ------------------------------------------------------------
  // Check register
  // ------------------------------------------------------------
  localparam int CRC_W = 16;
  localparam int TAP16_LO = 2;
  localparam int TAP16_HI = 15;
  localparam int TAPCC_LO = 5;
  localparam int TAPCC_HI = 12;
  // Octal 016417, logical value of a good bit-oriented frame
  localparam logic [CRC_W-1:0] SDLC_RESIDUE = 16'h1d0f;
  // Logical clear values per mode
  localparam logic [CRC_W-1:0] CLR_SDLC  = 16'hffff;
  localparam logic [CRC_W-1:0] CLR_DDCMP = 16'h0000;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [1:0]      CTRL_RST  = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST  = 2'h0;
  localparam logic [31:0]     RDATA_RST = 32'h0000_0000;

endpackage

// *** hw/rcc_crc_step.sv ***
`timescale 1ns/100ps
module rcc_crc_step (
  // Logical check value and serial bit
  input  wire logic [rcc_pkg::CRC_W-1:0] crc,
  input  wire logic                      inBit,
  input  wire logic                      polySel,
  // Value after one shift
  output logic      [rcc_pkg::CRC_W-1:0] nextCrc,
  output logic                           feedback
);
  import rcc_pkg::*;

  assign feedback = inBit ^ crc[CRC_W-1]; // RL1
  assign nextCrc[0] = feedback; // RL1

  // Taps not selected by the mode pass the previous stage unchanged
  for (genvar i = 1; i < CRC_W; i++) begin : g_stage
    localparam logic T16 = (i == TAP16_LO) || (i == TAP16_HI);
    localparam logic TCC = (i == TAPCC_LO) || (i == TAPCC_HI);
    assign nextCrc[i] = crc[i-1] ^ (feedback & (polySel ? T16 : TCC)); // RL2 RL9
  end

endmodule

// *** hw/rcc_event_bank.sv ***
`timescale 1ns/100ps
module rcc_event_bank (
  // Clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // Events and software access
  input  wire logic [rcc_pkg::EV_W-1:0] evIn,
  input  wire logic                     clrWe,
  input  wire logic                     maskWe,
  input  wire logic [rcc_pkg::EV_W-1:0] wdata,
  // State
  output logic      [rcc_pkg::EV_W-1:0] status,
  output logic      [rcc_pkg::EV_W-1:0] mask,
  output logic                          irq
);
  import rcc_pkg::*;

  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic            irq;
  } rcc_bank_s;

  rcc_bank_s s;
  rcc_bank_s next_s;

  always_comb begin
    next_s = s;
    // A new event wins over a write-one clear in the same cycle
    next_s.status = (s.status & ~(clrWe ? wdata : '0)) | evIn;
    if (maskWe) begin
      next_s.mask = wdata;
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{status: '0, mask: MASK_RST, irq: 1'b0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask   = s.mask;
  assign irq    = s.irq;

endmodule

// *** hw/rcc_receive_crc_checker.sv ***
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// [RL1] Feedback is received bit XOR stage 15, loaded into stage 0.
// [RL2] Byte-count mode also folds feedback into stages 2 and 15 (CRC-16).
// [RL3] Byte-count mode takes its serial bit from the bit-count stage.
// [RL4] Byte-count mode folds last eight check bits as they arrive.
// [RL5] Byte-count mode flags zero residue together with the check character.
// [RL6] Good byte-count message leaves the check register all zero.
// [RL7] Bit-oriented mode takes its serial bit from shift register bit 0.
// [RL8] Bit-oriented mode relies on closing flag to push check bits in.
// [RL9] Bit-oriented mode folds feedback into stages 5 and 12 (CCITT).
// [RL10] Data and received check field both enter the accumulation.
// [RL11] Bit-oriented mode starts the check register at all ones.
// [RL12] Sender transmits the bit-oriented check field inverted.
// [RL13] Bit-oriented good frame leaves octal 016417; else message error.
// [RL14] Stages store inverted levels: high means logical zero.
// [RL15] Register shifts once per bit pulse only while receiving.
// [RL16] Bit-oriented mode holds register cleared while receiver inactive.
// [RL17] Byte-count mode clears on last sync bit until receiver active.
// [RL18] Clearing receiver enable in byte-count mode clears the register.
module rcc_receive_crc_checker (
  // Clock, reset, enable
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // Avalon-MM slave
  input  wire logic [rcc_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Receiver path
  input  wire logic                       rxBitCountStage,
  input  wire logic                       rxShiftReg,
  input  wire logic                       bitTimePulse,
  input  wire logic                       rxCheckShiftEnable,
  input  wire logic                       rxActiveBit,
  input  wire logic                       syncCharBitLast,
  input  wire logic                       msgEnd,
  // Results
  output logic      [rcc_pkg::CRC_W-1:0]  rxCheckReg,
  output logic                            checkGood,
  output logic                            irq
);
  import rcc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CRC_W-1:0] stage;
    logic             polySel;
    logic             rxEn;
    logic             resOk;
    logic             waitReq;
    logic [31:0]      rdata;
  } rcc_state_s;

  rcc_state_s s;
  rcc_state_s next_s;

  logic [CRC_W-1:0] chk;
  logic [CRC_W-1:0] stepOut;
  logic             stepFb;
  logic             serialIn;
  logic             shiftNow;
  logic             clrNow;
  logic [CRC_W-1:0] clrVal;
  logic             match;
  logic             accept;
  logic             wrCtrl;
  logic             wrEvent;
  logic             wrMask;
  logic [EV_W-1:0]  events;
  logic [EV_W-1:0]  evStatus;
  logic [EV_W-1:0]  evMask;
  logic             bankIrq;

  // ------------------------------------------------------------
  // Check datapath
  // ------------------------------------------------------------
  // Stages hold inverted levels, so the logical value is the complement
  assign chk = ~s.stage; // RL14

  // Byte-count mode reads the bit-count stage so the final eight check
  // bits are folded as they arrive; no trailing pad is required
  assign serialIn = s.polySel ? rxBitCountStage : rxShiftReg; // RL3 RL4 RL7

  // Every bit in the shift window counts, check field included
  assign shiftNow = bitTimePulse & rxCheckShiftEnable; // RL15 RL10

  // Clears come from receiver activity, receiver enable and sync framing, per mode
  always_comb begin
    clrNow = 1'b0;
    clrVal = CLR_DDCMP;
    if (!s.polySel) begin
      clrNow = ~rxActiveBit; // RL16
      clrVal = CLR_SDLC; // RL11
    end else if (!s.rxEn) begin
      clrNow = 1'b1; // RL18
    end else if (syncCharBitLast && bitTimePulse && !rxActiveBit) begin
      clrNow = 1'b1; // RL17
    end
  end

  rcc_crc_step u_step (
    .crc      (chk),
    .inBit    (serialIn),
    .polySel  (s.polySel),
    .nextCrc  (stepOut),
    .feedback (stepFb)
  );

  // Byte-count good message ends at zero; bit-oriented at fixed residue.
  // The bit-oriented residue assumes the sender inverted its check field.
  assign match = s.polySel ? (chk == CLR_DDCMP) // RL6
                           : (chk == SDLC_RESIDUE); // RL13 RL12

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // One wait cycle per access keeps read data registered; the cost is
  // two cycles per access, so back-to-back transfers run at half rate
  assign accept  = (read | write) & ~s.waitReq;
  assign wrCtrl  = accept & write & (address == OFF_CTRL);
  assign wrEvent = accept & write & (address == OFF_EVENT);
  assign wrMask  = accept & write & (address == OFF_MASK);

  // End of message: check character (byte-count) or closing flag
  assign events[EV_PASS] = msgEnd & match; // RL5 RL8
  assign events[EV_FAIL] = msgEnd & ~match; // RL13

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    // One wait cycle, then the request is taken, then wait rises again
    next_s.waitReq = ~((read | write) & s.waitReq);
    if ((read | write) && s.waitReq) begin
      next_s.rdata = 32'h0000_0000;
      if (address == OFF_CTRL) begin
        next_s.rdata[CTRL_POLY] = s.polySel;
        next_s.rdata[CTRL_RXEN] = s.rxEn;
      end else if (address == OFF_STAT) begin
        next_s.rdata[CRC_W-1:0] = chk;
        next_s.rdata[STAT_RESOK] = s.resOk;
        next_s.rdata[STAT_ACT] = rxActiveBit;
      end else if (address == OFF_EVENT) begin
        next_s.rdata[EV_W-1:0] = evStatus;
      end else if (address == OFF_MASK) begin
        next_s.rdata[EV_W-1:0] = evMask;
      end
    end
    if (wrCtrl) begin
      next_s.polySel = writedata[CTRL_POLY];
      next_s.rxEn = writedata[CTRL_RXEN];
    end
    // Clear wins over a shift in the same cycle, so the last sync bit
    // is dropped even though it was shifted in
    if (clrNow) begin
      next_s.stage = ~clrVal; // RL14
    end else if (shiftNow) begin
      next_s.stage = ~stepOut; // RL1 RL2 RL9
    end
    if (msgEnd) begin
      next_s.resOk = match; // RL5 RL13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '{stage: ~CLR_DDCMP, polySel: CTRL_RST[CTRL_POLY],
             rxEn: CTRL_RST[CTRL_RXEN], resOk: 1'b0, waitReq: 1'b1,
             rdata: RDATA_RST};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // Events are sticky; software clears them by writing ones
  rcc_event_bank u_bank (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .evIn   (events),
    .clrWe  (wrEvent),
    .maskWe (wrMask),
    .wdata  (writedata[EV_W-1:0]),
    .status (evStatus),
    .mask   (evMask),
    .irq    (bankIrq)
  );

  assign readdata    = s.rdata;
  assign waitrequest = s.waitReq;
  assign rxCheckReg  = s.stage;
  assign checkGood   = s.resOk;
  assign irq         = bankIrq;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  feed_in_a: assert property ( // RL1
    ce && shiftNow && !clrNow |=>
      chk[0] == ($past(serialIn) ^ $past(chk[15])))
    else $error("stage 0 did not take the feedback");

  crc16_tap_a: assert property ( // RL2
    ce && shiftNow && !clrNow && s.polySel |=>
      chk[2] == ($past(chk[1]) ^ $past(stepFb)) &&
      chk[15] == ($past(chk[14]) ^ $past(stepFb)) &&
      chk[5] == $past(chk[4]) && chk[12] == $past(chk[11]))
    else $error("CRC-16 taps wrong");

  ccitt_tap_a: assert property ( // RL9
    ce && shiftNow && !clrNow && !s.polySel |=>
      chk[5] == ($past(chk[4]) ^ $past(stepFb)) &&
      chk[12] == ($past(chk[11]) ^ $past(stepFb)) &&
      chk[2] == $past(chk[1]) && chk[15] == $past(chk[14]))
    else $error("CCITT taps wrong");

  byte_src_a: assert property ( // RL3
    s.polySel |-> serialIn == rxBitCountStage)
    else $error("byte-count mode used wrong serial source");

  bit_src_a: assert property ( // RL7
    !s.polySel |-> serialIn == rxShiftReg)
    else $error("bit-oriented mode used wrong serial source");

  hold_still_a: assert property ( // RL15
    ce && !(bitTimePulse && rxCheckShiftEnable) && !clrNow
      && !wrCtrl |=> $stable(s.stage))
    else $error("check register moved without a bit pulse");

  sdlc_clr_a: assert property ( // RL16
    ce && !s.polySel && !rxActiveBit && !wrCtrl |=> s.stage == 16'h0000)
    else $error("bit-oriented clear not held to all ones");

  sync_clr_a: assert property ( // RL17
    ce && s.polySel && s.rxEn && syncCharBitLast && bitTimePulse
      && !rxActiveBit && !wrCtrl |=> chk == 16'h0000)
    else $error("sync character not cleared");

  rxen_clr_a: assert property ( // RL18
    ce && s.polySel && !s.rxEn && !wrCtrl |=> chk == 16'h0000)
    else $error("disabled receiver did not clear register");

  zero_res_a: assert property ( // RL5
    ce && msgEnd && s.polySel |=> checkGood == ($past(chk) == 16'h0000))
    else $error("zero residue flag wrong");

  residue_a: assert property ( // RL13
    ce && msgEnd && !s.polySel && !wrEvent |=>
      checkGood == ($past(chk) == 16'h1d0f)
      && evStatus[EV_FAIL] == ($past(chk) != 16'h1d0f
      || $past(evStatus[EV_FAIL])))
    else $error("frame residue check wrong");

  polarity_a: assert property ( // RL14
    ce && s.polySel && !s.rxEn && !wrCtrl |=> rxCheckReg == 16'hffff)
    else $error("stage levels not inverted");

  wait_answer_a: assert property (
    ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  wait_pulse_a: assert property (
    ce && !waitrequest |=> waitrequest)
    else $error("waitrequest stayed low past the accept");

  read_hold_a: assert property (
    ce && !waitrequest |=> $stable(readdata))
    else $error("read data changed after the accept");

  event_set_a: assert property ( // RL5
    ce && msgEnd |=> evStatus[EV_PASS] || evStatus[EV_FAIL])
    else $error("end of message left no event");

  clr_first_a: assert property ( // RL17
    ce && clrNow && shiftNow |=> chk == $past(clrVal))
    else $error("shift overrode a clear");

  good_frame_c: cover property (
    ce && msgEnd && !s.polySel && match);
  good_msg_c: cover property (
    ce && msgEnd && s.polySel && match);
  bad_msg_c: cover property (ce && msgEnd && !match ##1 irq);

  // ------------------------------------------------------------
  // Framing covers
  // ------------------------------------------------------------
  sync_clear_c: cover property (
    ce && s.polySel && syncCharBitLast && bitTimePulse && !rxActiveBit);
  idle_pulse_c: cover property (
    ce && bitTimePulse && !rxCheckShiftEnable && rxActiveBit);

endmodule

// *** test/rcc_rx_partner.sv ***
`timescale 1ns/100ps
module rcc_rx_partner (
  // Clock and pacing
  input  wire logic       clk,
  input  wire logic       byteMode,
  input  wire logic [3:0] gap,
  // Receiver path toward the checker
  output logic            rxBitCountStage,
  output logic            rxShiftReg,
  output logic            bitTimePulse,
  output logic            rxCheckShiftEnable,
  output logic            rxActiveBit,
  output logic            syncCharBitLast,
  output logic            msgEnd
);
  import rcc_pkg::*;
  initial begin
    rxBitCountStage    = 1'b0;
    rxShiftReg         = 1'b1;
    bitTimePulse       = 1'b0;
    rxCheckShiftEnable = 1'b0;
    rxActiveBit        = 1'b0;
    syncCharBitLast    = 1'b0;
    msgEnd             = 1'b0;
  end
  // The unused source carries the inverse bit, so a wrong pick shows
  task automatic send_bit(input logic b, input logic en, input logic last);
    @(posedge clk);
    rxBitCountStage    <= byteMode ? b : ~b;
    rxShiftReg         <= byteMode ? ~b : b;
    bitTimePulse       <= 1'b1;
    rxCheckShiftEnable <= en;
    syncCharBitLast    <= last;
    @(posedge clk);
    // Bit time over: lines no longer hold the old value
    rxBitCountStage    <= ~rxBitCountStage;
    rxShiftReg         <= ~rxShiftReg;
    bitTimePulse       <= 1'b0;
    rxCheckShiftEnable <= 1'b0;
    syncCharBitLast    <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
  task automatic set_active(input logic a);
    @(posedge clk);
    rxActiveBit <= a;
  endtask
  task automatic end_msg;
    @(posedge clk);
    msgEnd <= 1'b1;
    @(posedge clk);
    msgEnd <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// *** test/rcc_receive_crc_checker_test.sv ***
`timescale 1ns/100ps
module rcc_receive_crc_checker_test;
  import rcc_pkg::*;
  logic              clk, rst, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata, rd;
  logic [CRC_W-1:0]  rxCheckReg;
  logic              checkGood, irq, byteMode, lastGood, ce;
  logic              rxBitCountStage, rxShiftReg, bitTimePulse, msgEnd;
  logic              rxCheckShiftEnable, rxActiveBit, syncCharBitLast;
  logic [3:0]        gap;
  int                err_total, num_checks;

  always #2.5 clk = ~clk;

  rcc_receive_crc_checker rcc_receive_crc_checker_i (
    .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxBitCountStage(rxBitCountStage),
    .rxShiftReg(rxShiftReg), .bitTimePulse(bitTimePulse),
    .rxCheckShiftEnable(rxCheckShiftEnable), .rxActiveBit(rxActiveBit),
    .syncCharBitLast(syncCharBitLast), .msgEnd(msgEnd),
    .rxCheckReg(rxCheckReg), .checkGood(checkGood), .irq(irq));
  rcc_rx_partner rcc_rx_partner_i (
    .clk(clk), .byteMode(byteMode), .gap(gap),
    .rxBitCountStage(rxBitCountStage), .rxShiftReg(rxShiftReg),
    .bitTimePulse(bitTimePulse), .rxCheckShiftEnable(rxCheckShiftEnable),
    .rxActiveBit(rxActiveBit), .syncCharBitLast(syncCharBitLast),
    .msgEnd(msgEnd));

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Avalon master, entered just after a rising edge
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    n = 0;
    // Request held until the rising edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      err_total++;
      end_of_test();
    end
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    cmp_word(rd, e);
  endtask

  // ------------------------------------------------------------
  // Reference check value and frames
  // ------------------------------------------------------------
  function automatic logic [15:0] step(logic [15:0] c, logic b, logic p);
    logic        fb;
    logic [15:0] n;
    fb = b ^ c[15];
    n = {c[14:0], fb};
    if (p) begin
      n[TAP16_LO] = n[TAP16_LO] ^ fb;
      n[TAP16_HI] = n[TAP16_HI] ^ fb;
    end else begin
      n[TAPCC_LO] = n[TAPCC_LO] ^ fb;
      n[TAPCC_HI] = n[TAPCC_HI] ^ fb;
    end
    return n;
  endfunction
  function automatic logic [31:0] stat(logic act, logic [15:0] c);
    return {14'h0, act, lastGood, c};
  endfunction

  task automatic run_frame(input logic p, input logic [31:0] dat,
                           input int nb, input logic bad, input logic [3:0] g);
    logic [15:0] c;
    logic [15:0] f;
    int          i;
    byteMode <= p;
    gap      <= g;
    wr_reg(OFF_CTRL, {30'h0, 1'b1, p});
    for (i = 0; i < 8; i++)
      rcc_rx_partner_i.send_bit(logic'(i % 2), 1'b1, p && i == 7);
    rd_chk(OFF_STAT, stat(1'b0, p ? CLR_DDCMP : CLR_SDLC));
    rcc_rx_partner_i.set_active(1'b1);
    c = p ? CLR_DDCMP : CLR_SDLC;
    for (i = nb - 1; i >= 0; i--) begin
      rcc_rx_partner_i.send_bit(dat[i], 1'b1, 1'b0);
      c = step(c, dat[i], p);
    end
    rcc_rx_partner_i.send_bit(~c[15], 1'b0, 1'b0);
    f = p ? c : ~c;
    f[0] = f[0] ^ bad;
    for (i = 15; i >= 0; i--) begin
      rcc_rx_partner_i.send_bit(f[i], 1'b1, 1'b0);
      c = step(c, f[i], p);
    end
    rd_chk(OFF_STAT, stat(1'b1, c));
    cmp_word({16'h0, rxCheckReg}, {16'h0, ~c});
    rcc_rx_partner_i.end_msg();
    lastGood = ~bad;
    cmp_bit(checkGood, ~bad);
    rd_chk(OFF_STAT, stat(1'b1, c));
    rd_chk(OFF_EVENT, bad ? 32'h2 : 32'h1);
    cmp_bit(irq, 1'b0);
    wr_reg(OFF_MASK, 32'h3);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b1);
    rd_chk(OFF_MASK, 32'h3);
    wr_reg(OFF_EVENT, 32'h3);
    repeat (2) @(posedge clk);
    cmp_bit(irq, 1'b0);
    rd_chk(OFF_EVENT, 32'h0);
    wr_reg(OFF_MASK, 32'h0);
    rcc_rx_partner_i.set_active(1'b0);
    if (p) begin
      wr_reg(OFF_CTRL, {31'h0, p});
      rd_chk(OFF_STAT, stat(1'b0, 16'h0));
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = 32'h0;
    byteMode = 1'b0;
    ce = 1'b1;
    gap = 4'h0;
    lastGood = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    cmp_bit(waitrequest, 1'b1);
    // Reset leaves bit-oriented mode, so the inactive receiver holds ones
    cmp_word({16'h0, rxCheckReg}, 32'h0000_0000);
    rd_chk(OFF_CTRL, {30'h0, CTRL_RST});
    rd_chk(OFF_MASK, {30'h0, MASK_RST});
    rd_chk(OFF_EVENT, 32'h0);
    rd_chk(OFF_STAT, 32'h0000_ffff);
    wr_reg(4'h2, 32'hffff_ffff);
    rd_chk(4'h2, 32'h0);
    run_frame(1'b1, 32'h0005_a3c9, 19, 1'b0, 4'h0);
    run_frame(1'b1, 32'h0000_00c3, 8, 1'b1, 4'h2);
    run_frame(1'b0, 32'h0005_a3c9, 19, 1'b0, 4'h0);
    run_frame(1'b0, 32'h0000_07e1, 11, 1'b1, 4'h3);
    // Clock enable low must freeze the register through a bit pulse
    wr_reg(OFF_CTRL, 32'h0000_0003);
    byteMode <= 1'b1;
    ce <= 1'b0;
    rcc_rx_partner_i.send_bit(1'b1, 1'b1, 1'b0);
    cmp_word({16'h0, rxCheckReg}, 32'h0000_0000);
    ce <= 1'b1;
    rcc_rx_partner_i.send_bit(1'b1, 1'b1, 1'b0);
    rd = {16'h0, ~step(16'hffff, 1'b1, 1'b1)};
    cmp_word({16'h0, rxCheckReg}, rd);
    end_of_test();
  end
endmodule
